// >>> hw/lmu_pkg.sv
// Constants shared by the lighting control register bank and its fade ramp.
// Assumes a single 125 MHz clock domain and byte-wide register accesses.
package lmu_pkg;

  // ==========================================================================
  // Register map
  localparam int LMU_NUM_REGS = 11;
  localparam logic [7:0] LMU_ADDR_KEY_LED_CONFIG = 8'h00;
  localparam logic [7:0] LMU_ADDR_KEY_DIMMING = 8'h01;
  localparam logic [7:0] LMU_ADDR_KEY_CURRENT_LIMITS = 8'h02;
  localparam logic [7:0] LMU_ADDR_BACKLIGHT_CONFIG = 8'h03;
  localparam logic [7:0] LMU_ADDR_PRIMARY_CURRENT = 8'h04;
  localparam logic [7:0] LMU_ADDR_SECONDARY_CURRENT = 8'h05;
  localparam logic [7:0] LMU_ADDR_GPIO_CONFIG = 8'h06;
  localparam logic [7:0] LMU_ADDR_GPIO_VALUE = 8'h07;
  localparam logic [7:0] LMU_ADDR_POWER_ENABLES = 8'h0b;
  localparam logic [7:0] LMU_ADDR_STEP_UP_VOLTAGE = 8'h0d;
  localparam logic [7:0] LMU_ADDR_EXT_DIMMING_ENABLES = 8'h2b;

  // Storage slot of each register inside the bank.
  localparam logic [3:0] LMU_IDX_CFG = 4'h0;
  localparam logic [3:0] LMU_IDX_DIM = 4'h1;
  localparam logic [3:0] LMU_IDX_LIM = 4'h2;
  localparam logic [3:0] LMU_IDX_BL = 4'h3;
  localparam logic [3:0] LMU_IDX_PRI = 4'h4;
  localparam logic [3:0] LMU_IDX_SEC = 4'h5;
  localparam logic [3:0] LMU_IDX_GCFG = 4'h6;
  localparam logic [3:0] LMU_IDX_GVAL = 4'h7;
  localparam logic [3:0] LMU_IDX_PWR = 4'h8;
  localparam logic [3:0] LMU_IDX_VOLT = 4'h9;
  localparam logic [3:0] LMU_IDX_EXT = 4'ha;

  // ==========================================================================
  // Reset values and writable bits, highest slot first
  localparam logic [LMU_NUM_REGS-1:0][7:0] LMU_RESET_IMAGE = {
    8'h00, 8'h08, 8'h04, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h20};
  localparam logic [LMU_NUM_REGS-1:0][7:0] LMU_WRITE_MASK = {
    8'h1f, 8'hff, 8'h64, 8'h07, 8'h17, 8'hff,
    8'hff, 8'h3f, 8'h3f, 8'h7f, 8'hee};

  // ==========================================================================
  // Field positions
  localparam int LMU_CFG_INT_DIM = 7;
  localparam int LMU_CFG_OUTPUTS_EN = 6;
  localparam int LMU_CFG_DRIVE_STYLE = 5;
  localparam int LMU_CFG_SINK_ONE = 3;
  localparam int LMU_CFG_SINK_TWO = 2;
  localparam int LMU_CFG_SINK_THREE = 1;
  localparam int LMU_DIM_BAL_LSB = 4;
  localparam int LMU_DIM_BRIGHT_LSB = 1;
  localparam int LMU_DIM_OVERLAP = 0;
  localparam int LMU_LIM_ONE_LSB = 4;
  localparam int LMU_LIM_TWO_LSB = 2;
  localparam int LMU_LIM_THREE_LSB = 0;
  localparam int LMU_BL_SLOPE = 5;
  localparam int LMU_BL_FADE_SEL = 4;
  localparam int LMU_BL_FADE_EN = 3;
  localparam int LMU_BL_SHARED = 2;
  localparam int LMU_BL_PRI_EN = 1;
  localparam int LMU_BL_SEC_EN = 0;
  localparam int LMU_GCFG_PIN_EN = 4;
  localparam int LMU_PWR_ACTIVE = 6;
  localparam int LMU_PWR_STEP_UP = 5;
  localparam int LMU_PWR_DUMMY = 2;
  localparam int LMU_EXT_ONE = 4;
  localparam int LMU_EXT_TWO = 3;
  localparam int LMU_EXT_THREE = 2;
  localparam int LMU_EXT_PRI = 1;
  localparam int LMU_EXT_SEC = 0;

  // ==========================================================================
  // Fade timing: full scale is 255 steps of 0.1 mA
  localparam int LMU_CLK_KHZ = 125000;
  localparam int LMU_FADE_FAST_MS = 650;
  localparam int LMU_FADE_SLOW_MS = 1300;
  localparam int LMU_FADE_STEPS = 255;
  localparam int LMU_FADE_FAST_STEP_CYC =
    LMU_FADE_FAST_MS * LMU_CLK_KHZ / LMU_FADE_STEPS;
  localparam int LMU_FADE_SLOW_STEP_CYC =
    LMU_FADE_SLOW_MS * LMU_CLK_KHZ / LMU_FADE_STEPS;

  typedef logic [7:0] lmu_byte_t;

  typedef enum logic [1:0] {
    LMU_FADE_HOLD = 2'b01,
    LMU_FADE_STEP = 2'b10
  } lmu_fade_state_e;

endpackage

// >>> hw/lmu_fade_if.sv
// Link between the register bank and the backlight fade ramp.
// Assumes both ends share one clock.
`timescale 1ns/1ps
`default_nettype none
interface lmu_fade_if;
  import lmu_pkg::*;
  logic en;
  logic slow;
  lmu_byte_t target;
  lmu_byte_t level;
  logic busy;
  modport ctrl (output en, output slow, output target,
                input level, input busy);
  modport ramp (input en, input slow, input target,
                output level, output busy);
endinterface
`default_nettype wire

// >>> hw/lmu_fade_ramp.sv
// Backlight fade ramp: walks a current code one step at a time to a target.
// Assumes a synchronous active-high reset and one clock domain.
`timescale 1ns/1ps
`default_nettype none
module lmu_fade_ramp
  import lmu_pkg::*;
#(
  parameter int FAST_STEP_CYC = LMU_FADE_FAST_STEP_CYC,
  parameter int SLOW_STEP_CYC = LMU_FADE_SLOW_STEP_CYC,
  parameter int CNT_W = 20
) (
  input wire logic clk,
  input wire logic rst,
  lmu_fade_if.ramp fade
);

  typedef struct packed {
    lmu_fade_state_e st;
    lmu_byte_t level;
    logic [CNT_W-1:0] cnt;
  } lmu_ramp_s;

  localparam logic [CNT_W-1:0] FAST_LAST = CNT_W'(FAST_STEP_CYC - 1);
  localparam logic [CNT_W-1:0] SLOW_LAST = CNT_W'(SLOW_STEP_CYC - 1);

  lmu_ramp_s state_q;
  lmu_ramp_s state_d;

  // ==========================================================================
  // Step scheduling
  // One step per period means a full 0..255 sweep takes the full-scale time.
  always_comb begin
    state_d = state_q;
    if (!fade.en) begin
      state_d.level = fade.target;
      state_d.cnt = '0;
      state_d.st = LMU_FADE_HOLD;
    end else begin
      unique case (state_q.st)
        LMU_FADE_HOLD: begin
          state_d.cnt = '0;
          if (state_q.level != fade.target) begin
            state_d.st = LMU_FADE_STEP;
          end
        end
        LMU_FADE_STEP: begin
          if (state_q.level == fade.target) begin
            state_d.st = LMU_FADE_HOLD;
            state_d.cnt = '0;
          end else if (state_q.cnt ==
                       (fade.slow ? SLOW_LAST : FAST_LAST)) begin
            state_d.cnt = '0;
            if (state_q.level < fade.target) begin
              state_d.level = state_q.level + 8'h01;
            end else begin
              state_d.level = state_q.level - 8'h01;
            end
          end else begin
            state_d.cnt = state_q.cnt + {{(CNT_W-1){1'b0}}, 1'b1};
          end
        end
        default: begin
          state_d.st = LMU_FADE_HOLD;
          state_d.cnt = '0;
        end
      endcase
    end
  end

  // State register.
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q <= '{st: LMU_FADE_HOLD, level: 8'h00, cnt: '0};
    end else begin
      state_q <= state_d;
    end
  end

  assign fade.level = state_q.level;
  assign fade.busy = (state_q.level != fade.target) && fade.en;

endmodule // lmu_fade_ramp
`default_nettype wire

// >>> hw/lmu_light_regs.sv
// Control register bank of the lighting management unit, with the drive
// controls it hands to the keypad sinks, backlight strings, GPIO and step-up.
// Assumes an upstream two-wire serial engine turns frames into byte-wide
// read and write strobes in the clk domain.
`timescale 1ns/1ps
`default_nettype none

module lmu_light_regs
  import lmu_pkg::*;
#(
  parameter int FAST_STEP_CYC = LMU_FADE_FAST_STEP_CYC,
  parameter int SLOW_STEP_CYC = LMU_FADE_SLOW_STEP_CYC
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic external_reset_low,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  output logic reg_rd_valid,
  output logic active_not_sleep,
  output logic [2:0] key_sink_en,
  output logic keypad_internal_dimming_en,
  output logic keypad_drive_style,
  output logic [2:0] keypad_balance,
  output logic [2:0] keypad_brightness,
  output logic overlap_mode_en,
  output logic [1:0] key_sink_one_limit,
  output logic [1:0] key_sink_two_limit,
  output logic [1:0] key_sink_three_limit,
  output logic primary_on,
  output logic secondary_on,
  output logic [7:0] primary_level,
  output logic [7:0] secondary_level,
  output logic fade_busy,
  input wire logic [2:0] gpio_in,
  output logic [2:0] gpio_out,
  output logic [2:0] gpio_oe,
  output logic ext_dimming_pin_en,
  output logic [2:0] key_sink_ext_dimming_en,
  output logic primary_ext_dimming_en,
  output logic secondary_ext_dimming_en,
  output logic step_up_en,
  output logic step_up_dummy_load_en,
  output logic [7:0] step_up_voltage_code
);

  // ==========================================================================
  // State
  typedef struct packed {
    logic [LMU_NUM_REGS-1:0][7:0] regs;
    lmu_byte_t rdata;
    logic rd_valid;
    logic active;
    logic [2:0] key_en;
    logic key_int_dim;
    logic drive_style;
    logic [2:0] balance;
    logic [2:0] bright;
    logic overlap;
    logic [5:0] limits;
    logic pri_on;
    logic sec_on;
    lmu_byte_t pri_lvl;
    lmu_byte_t sec_lvl;
    logic [2:0] gpio_oe;
    logic [2:0] gpio_out;
    logic pin_en;
    logic [4:0] ext_dim;
    logic step_up;
    logic dummy;
    lmu_byte_t volt;
  } lmu_regs_s;

  localparam lmu_regs_s RESET_STATE = '{
    regs: LMU_RESET_IMAGE,
    drive_style: 1'b1,
    dummy: 1'b1,
    volt: 8'h08,
    default: '0
  };

  lmu_regs_s state_q;
  lmu_regs_s state_d;
  logic rst_any;
  logic [4:0] wr_hit;
  logic [4:0] rd_hit;
  lmu_byte_t cfg;
  lmu_byte_t dim;
  lmu_byte_t lim;
  lmu_byte_t bl;
  lmu_byte_t gcfg;
  lmu_byte_t gval;
  lmu_byte_t pwr;
  lmu_byte_t ext;
  lmu_byte_t pri_tgt;
  lmu_byte_t sec_tgt;
  logic fade_on;
  logic fade_sec;

  lmu_fade_if fade_bus ();

  // ==========================================================================
  // Address decode, shared by the write and read paths
  // Returns {hit, slot}; an unmapped address gives hit low.
  function automatic logic [4:0] decode(input logic [7:0] addr);
    logic [4:0] res;
    res = 5'h00;
    unique case (addr)
      LMU_ADDR_KEY_LED_CONFIG: res = {1'b1, LMU_IDX_CFG};
      LMU_ADDR_KEY_DIMMING: res = {1'b1, LMU_IDX_DIM};
      LMU_ADDR_KEY_CURRENT_LIMITS: res = {1'b1, LMU_IDX_LIM};
      LMU_ADDR_BACKLIGHT_CONFIG: res = {1'b1, LMU_IDX_BL};
      LMU_ADDR_PRIMARY_CURRENT: res = {1'b1, LMU_IDX_PRI};
      LMU_ADDR_SECONDARY_CURRENT: res = {1'b1, LMU_IDX_SEC};
      LMU_ADDR_GPIO_CONFIG: res = {1'b1, LMU_IDX_GCFG};
      LMU_ADDR_GPIO_VALUE: res = {1'b1, LMU_IDX_GVAL};
      LMU_ADDR_POWER_ENABLES: res = {1'b1, LMU_IDX_PWR};
      LMU_ADDR_STEP_UP_VOLTAGE: res = {1'b1, LMU_IDX_VOLT};
      LMU_ADDR_EXT_DIMMING_ENABLES: res = {1'b1, LMU_IDX_EXT};
      default: res = 5'h00;
    endcase
    return res;
  endfunction

  // Either reset source loads the reset image; the pin is taken as synchronous.
  assign rst_any = sys_rst | ~external_reset_low;
  assign wr_hit = decode(reg_addr);
  assign rd_hit = decode(reg_addr);

  // Named views of the stored registers.
  assign cfg = state_q.regs[LMU_IDX_CFG];
  assign dim = state_q.regs[LMU_IDX_DIM];
  assign lim = state_q.regs[LMU_IDX_LIM];
  assign bl = state_q.regs[LMU_IDX_BL];
  assign gcfg = state_q.regs[LMU_IDX_GCFG];
  assign gval = state_q.regs[LMU_IDX_GVAL];
  assign pwr = state_q.regs[LMU_IDX_PWR];
  assign ext = state_q.regs[LMU_IDX_EXT];

  // ==========================================================================
  // Backlight targets and the fade ramp
  // In shared mode the secondary string takes the primary code as well.
  assign pri_tgt = state_q.regs[LMU_IDX_PRI];
  assign sec_tgt = bl[LMU_BL_SHARED] ? pri_tgt
                 : state_q.regs[LMU_IDX_SEC];
  assign fade_on = bl[LMU_BL_FADE_EN] & pwr[LMU_PWR_ACTIVE];
  assign fade_sec = bl[LMU_BL_FADE_SEL];

  // Only one string fades; in shared mode the other mirrors the primary.
  assign fade_bus.en = fade_on;
  assign fade_bus.slow = bl[LMU_BL_SLOPE];
  assign fade_bus.target = fade_sec ? sec_tgt : pri_tgt;

  lmu_fade_ramp #(
    .FAST_STEP_CYC(FAST_STEP_CYC),
    .SLOW_STEP_CYC(SLOW_STEP_CYC)
  ) u_fade (
    .clk(clk),
    .rst(rst_any),
    .fade(fade_bus.ramp)
  );

  // ==========================================================================
  // Next-state logic
  // The drive fields are recomputed from the stored bytes every cycle, so a
  // write reaches the outputs one cycle after the register itself changes.
  always_comb begin
    lmu_byte_t pri_eff;
    lmu_byte_t sec_eff;
    logic act;
    state_d = state_q;
    pri_eff = pri_tgt;
    sec_eff = sec_tgt;
    act = pwr[LMU_PWR_ACTIVE];

    // Host write: only writable bits are stored, the rest stay zero.
    if (reg_wr_en && wr_hit[4]) begin
      state_d.regs[wr_hit[3:0]] = reg_wdata & LMU_WRITE_MASK[wr_hit[3:0]];
    end

    // Host read: unmapped addresses return zero. Input GPIO pins read back
    // their pin level, output pins the stored drive value.
    state_d.rd_valid = reg_rd_en;
    if (reg_rd_en) begin
      if (!rd_hit[4]) begin
        state_d.rdata = 8'h00;
      end else if (rd_hit[3:0] == LMU_IDX_GVAL) begin
        state_d.rdata = {5'h00, (gval[2:0] & gcfg[2:0])
                         | (gpio_in & ~gcfg[2:0])};
      end else begin
        state_d.rdata = state_q.regs[rd_hit[3:0]];
      end
    end

    // Keypad: standby and the master gate both force every sink off.
    state_d.active = act;
    state_d.key_en = {cfg[LMU_CFG_SINK_ONE], cfg[LMU_CFG_SINK_TWO],
                      cfg[LMU_CFG_SINK_THREE]}
                     & {3{cfg[LMU_CFG_OUTPUTS_EN] & act}};
    state_d.key_int_dim = cfg[LMU_CFG_INT_DIM]
                          & cfg[LMU_CFG_OUTPUTS_EN] & act;
    state_d.drive_style = cfg[LMU_CFG_DRIVE_STYLE];
    state_d.balance = dim[LMU_DIM_BAL_LSB +: 3];
    state_d.bright = dim[LMU_DIM_BRIGHT_LSB +: 3];
    state_d.overlap = dim[LMU_DIM_OVERLAP];
    state_d.limits = {lim[LMU_LIM_ONE_LSB +: 2], lim[LMU_LIM_TWO_LSB +: 2],
                      lim[LMU_LIM_THREE_LSB +: 2]};

    // Backlight: the fading string takes the ramp level.
    if (fade_on && !fade_sec) begin
      pri_eff = fade_bus.level;
    end
    if (fade_on && fade_sec) begin
      sec_eff = fade_bus.level;
    end
    if (bl[LMU_BL_SHARED]) begin
      sec_eff = pri_eff;
    end
    state_d.pri_on = bl[LMU_BL_PRI_EN] & act;
    state_d.sec_on = bl[LMU_BL_SEC_EN] & act;
    state_d.pri_lvl = state_d.pri_on ? pri_eff : 8'h00;
    state_d.sec_lvl = state_d.sec_on ? sec_eff : 8'h00;

    // GPIO: drive only pins set as outputs.
    state_d.gpio_oe = gcfg[2:0];
    state_d.gpio_out = gval[2:0] & gcfg[2:0];

    // External dimming: per-output selects are qualified by the pin enable.
    state_d.pin_en = gcfg[LMU_GCFG_PIN_EN];
    state_d.ext_dim = {ext[LMU_EXT_ONE], ext[LMU_EXT_TWO], ext[LMU_EXT_THREE],
                       ext[LMU_EXT_PRI], ext[LMU_EXT_SEC]}
                      & {5{gcfg[LMU_GCFG_PIN_EN]}};

    // Step-up converter; standby also stops it.
    state_d.step_up = pwr[LMU_PWR_STEP_UP] & act;
    state_d.dummy = pwr[LMU_PWR_DUMMY];
    state_d.volt = state_q.regs[LMU_IDX_VOLT];
  end

  // ==========================================================================
  // State register
  always_ff @(posedge clk) begin
    if (rst_any) begin
      state_q <= RESET_STATE;
    end else begin
      state_q <= state_d;
    end
  end

  // ==========================================================================
  // Outputs, all straight from flip-flops except fade_busy, which is decoded from the ramp
  assign reg_rdata = state_q.rdata;
  assign reg_rd_valid = state_q.rd_valid;
  assign active_not_sleep = state_q.active;
  assign key_sink_en = state_q.key_en;
  assign keypad_internal_dimming_en = state_q.key_int_dim;
  assign keypad_drive_style = state_q.drive_style;
  assign keypad_balance = state_q.balance;
  assign keypad_brightness = state_q.bright;
  assign overlap_mode_en = state_q.overlap;
  assign key_sink_one_limit = state_q.limits[5:4];
  assign key_sink_two_limit = state_q.limits[3:2];
  assign key_sink_three_limit = state_q.limits[1:0];
  assign primary_on = state_q.pri_on;
  assign secondary_on = state_q.sec_on;
  assign primary_level = state_q.pri_lvl;
  assign secondary_level = state_q.sec_lvl;
  assign fade_busy = fade_bus.busy;
  assign gpio_out = state_q.gpio_out;
  assign gpio_oe = state_q.gpio_oe;
  assign ext_dimming_pin_en = state_q.pin_en;
  assign key_sink_ext_dimming_en = state_q.ext_dim[4:2];
  assign primary_ext_dimming_en = state_q.ext_dim[1];
  assign secondary_ext_dimming_en = state_q.ext_dim[0];
  assign step_up_en = state_q.step_up;
  assign step_up_dummy_load_en = state_q.dummy;
  assign step_up_voltage_code = state_q.volt;

endmodule // lmu_light_regs
`default_nettype wire

// >>> test/lmu_light_regs_checker.sv
// Checker for the lighting register bank, bound to its top-level ports.
// Assumes one clock domain and a synchronous active-high sys_rst.
`timescale 1ns/1ps
`default_nettype none
module lmu_light_regs_checker
  import lmu_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic external_reset_low,
  input wire logic reg_wr_en,
  input wire logic reg_rd_en,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rd_valid,
  input wire logic active_not_sleep,
  input wire logic [2:0] key_sink_en,
  input wire logic keypad_internal_dimming_en,
  input wire logic keypad_drive_style,
  input wire logic primary_on,
  input wire logic [7:0] primary_level,
  input wire logic [2:0] gpio_out,
  input wire logic [2:0] gpio_oe,
  input wire logic ext_dimming_pin_en,
  input wire logic [2:0] key_sink_ext_dimming_en,
  input wire logic primary_ext_dimming_en,
  input wire logic step_up_en,
  input wire logic step_up_dummy_load_en,
  input wire logic [7:0] step_up_voltage_code
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  // ==========================================================================
  // Read and write steps
  sequence s_read(logic [7:0] a);
    reg_rd_en && reg_addr == a;
  endsequence
  sequence s_unmapped;
    reg_rd_en && !(reg_addr inside {[8'h00:8'h07], 8'h0b, 8'h0d, 8'h2b});
  endsequence
  // The local copy keeps the written byte even if wdata moves on.
  property p_volt_write;
    logic [7:0] v;
    (reg_wr_en && reg_addr == LMU_ADDR_STEP_UP_VOLTAGE, v = reg_wdata)
      |-> ##2 step_up_voltage_code == v;
  endproperty

  // ==========================================================================
  // Properties
  a_read_answer: assert property (reg_rd_en |=> reg_rd_valid)
    else $error("read strobe got no answer");
  a_valid_cause: assert property (reg_rd_valid |-> $past(reg_rd_en))
    else $error("read valid without a read");
  a_unmapped_zero: assert property (s_unmapped |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_cfg_ro_zero: assert property (
    s_read(LMU_ADDR_KEY_LED_CONFIG) |=> (reg_rdata & 8'h11) == 8'h00)
    else $error("read-only config bits not zero");
  a_pwr_ro_zero: assert property (
    s_read(LMU_ADDR_POWER_ENABLES) |=> (reg_rdata & 8'h9b) == 8'h00)
    else $error("read-only enable bits not zero");
  a_standby_keys: assert property (
    (key_sink_en != 3'b000 || keypad_internal_dimming_en) |-> active_not_sleep)
    else $error("keypad driven in standby");
  a_step_up_gate: assert property (step_up_en |-> active_not_sleep)
    else $error("step-up on in standby");
  a_string_off: assert property (!primary_on |-> primary_level == 8'h00)
    else $error("level shown on a disabled string");
  a_ext_gate: assert property (
    (key_sink_ext_dimming_en != 3'b000 || primary_ext_dimming_en)
      |-> ext_dimming_pin_en)
    else $error("external dimming without pin enable");
  a_gpio_drive: assert property ((gpio_out & ~gpio_oe) == 3'b000)
    else $error("data on an input pin");
  a_volt_write: assert property (p_volt_write)
    else $error("voltage code did not follow write");
  a_pin_reset: assert property (!external_reset_low |-> ##2
    (step_up_voltage_code == 8'h08 && step_up_dummy_load_en
     && keypad_drive_style))
    else $error("reset pin left wrong defaults");
endmodule // lmu_light_regs_checker

bind lmu_light_regs lmu_light_regs_checker i_lmu_light_regs_checker (
  .clk, .sys_rst, .external_reset_low, .reg_wr_en, .reg_rd_en, .reg_addr,
  .reg_wdata, .reg_rdata, .reg_rd_valid, .active_not_sleep, .key_sink_en,
  .keypad_internal_dimming_en, .keypad_drive_style, .primary_on,
  .primary_level, .gpio_out, .gpio_oe, .ext_dimming_pin_en,
  .key_sink_ext_dimming_en, .primary_ext_dimming_en, .step_up_en,
  .step_up_dummy_load_en, .step_up_voltage_code);
`default_nettype wire

// >>> test/lmu_host.sv
// Host model: issues byte-wide register writes and reads to the bank.
// Assumes the bank answers a read one clock after the strobe.
`timescale 1ns/1ps
`default_nettype none
module lmu_host (
  input wire logic clk,
  output logic wr_en,
  output logic rd_en,
  output logic [7:0] addr,
  output logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic rd_valid
);
  // Idle bus; released lines show the inverse so stale data never matches.
  initial begin
    wr_en = 1'b0;
    rd_en = 1'b0;
    addr = 8'hff;
    wdata = 8'hff;
  end

  // ==========================================================================
  // Transfers
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    wr_en <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask

  // A missing valid pulse returns unknown, so the caller's compare fails.
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    rd_en <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    addr <= ~a;
    #1;
    d = (rd_valid === 1'b1) ? rdata : 8'hxx;
  endtask
endmodule // lmu_host
`default_nettype wire

// >>> test/tb.sv
// Self-checking bench for the lighting register bank.
// Assumes short fade steps (4 and 8 clocks) so ramps finish quickly.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import lmu_pkg::*;
  logic clk, sys_rst, external_reset_low, reg_wr_en, reg_rd_en, reg_rd_valid;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, primary_level, secondary_level;
  logic [7:0] step_up_voltage_code;
  logic [2:0] key_sink_en, keypad_balance, keypad_brightness, gpio_in;
  logic [2:0] gpio_out, gpio_oe, key_sink_ext_dimming_en;
  logic [1:0] key_sink_one_limit, key_sink_two_limit, key_sink_three_limit;
  logic active_not_sleep, keypad_internal_dimming_en, keypad_drive_style;
  logic overlap_mode_en, primary_on, secondary_on, fade_busy;
  logic ext_dimming_pin_en, primary_ext_dimming_en, secondary_ext_dimming_en;
  logic step_up_en, step_up_dummy_load_en;
  int failures = 0;
  int check_count = 0;
  int nf, ns;
  localparam logic [7:0] addr_tab [LMU_NUM_REGS] = '{
    LMU_ADDR_KEY_LED_CONFIG, LMU_ADDR_KEY_DIMMING, LMU_ADDR_KEY_CURRENT_LIMITS,
    LMU_ADDR_BACKLIGHT_CONFIG, LMU_ADDR_PRIMARY_CURRENT,
    LMU_ADDR_SECONDARY_CURRENT, LMU_ADDR_GPIO_CONFIG, LMU_ADDR_GPIO_VALUE,
    LMU_ADDR_POWER_ENABLES, LMU_ADDR_STEP_UP_VOLTAGE,
    LMU_ADDR_EXT_DIMMING_ENABLES};

  lmu_light_regs #(.FAST_STEP_CYC(4), .SLOW_STEP_CYC(8)) i_lmu_light_regs (
    .clk, .sys_rst, .external_reset_low, .reg_wr_en, .reg_rd_en, .reg_addr,
    .reg_wdata, .reg_rdata, .reg_rd_valid, .active_not_sleep, .key_sink_en,
    .keypad_internal_dimming_en, .keypad_drive_style, .keypad_balance,
    .keypad_brightness, .overlap_mode_en, .key_sink_one_limit,
    .key_sink_two_limit, .key_sink_three_limit, .primary_on, .secondary_on,
    .primary_level, .secondary_level, .fade_busy, .gpio_in, .gpio_out,
    .gpio_oe, .ext_dimming_pin_en, .key_sink_ext_dimming_en,
    .primary_ext_dimming_en, .secondary_ext_dimming_en, .step_up_en,
    .step_up_dummy_load_en, .step_up_voltage_code);
  lmu_host i_lmu_host (.clk(clk), .wr_en(reg_wr_en), .rd_en(reg_rd_en),
    .addr(reg_addr), .wdata(reg_wdata), .rdata(reg_rdata),
    .rd_valid(reg_rd_valid));

  // ==========================================================================
  // Clock and helpers
  initial clk = 1'b0;
  always #4 clk = ~clk;

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] d;
    i_lmu_host.rd(a, d);
    chk(d, exp);
  endtask

  // Drive outputs lag the register by one edge, so wait two.
  task automatic settle;
    repeat (2) @(posedge clk);
    #1;
  endtask

  // Bounded wait for the ramp to reach its target; n is the cycles taken.
  task automatic fade_wait(output int n);
    n = 0;
    while (fade_busy !== 1'b0 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    chk(8'(n < 500), 8'h01);
    // The level outputs are registered from the ramp, so they lag one edge.
    @(posedge clk);
    #1;
  endtask

  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Watchdog: the whole sequence needs well under a tenth of this span.
  initial begin
    #100000;
    failures++;
    summarize();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    sys_rst = 1'b1;
    external_reset_low = 1'b1;
    gpio_in = 3'b101;
    repeat (12) @(posedge clk);
    sys_rst <= 1'b0;
    for (int i = 0; i < LMU_NUM_REGS; i++)
      rchk(addr_tab[i], i == 7 ? 8'h05 : LMU_RESET_IMAGE[i]);
    chk({keypad_drive_style, step_up_dummy_load_en, active_not_sleep,
         step_up_en, 1'b0, gpio_oe}, 8'hc0);
    chk(step_up_voltage_code, 8'h08);
    i_lmu_host.wr(8'h08, 8'hff);
    rchk(8'h08, 8'h00);
    for (int i = 0; i < LMU_NUM_REGS; i++) begin
      i_lmu_host.wr(addr_tab[i], 8'hff);
      rchk(addr_tab[i], LMU_WRITE_MASK[i]);
    end
    i_lmu_host.wr(LMU_ADDR_BACKLIGHT_CONFIG, 8'h07);
    settle();
    chk({key_sink_en, keypad_internal_dimming_en, keypad_drive_style,
         overlap_mode_en, primary_on, secondary_on}, 8'hff);
    chk({keypad_balance, keypad_brightness, key_sink_one_limit}, 8'hff);
    chk({key_sink_two_limit, key_sink_three_limit, gpio_out,
         ext_dimming_pin_en}, 8'hff);
    chk({key_sink_ext_dimming_en, primary_ext_dimming_en,
         secondary_ext_dimming_en, step_up_en, step_up_dummy_load_en,
         gpio_oe[0]}, 8'hff);
    chk(step_up_voltage_code, 8'hff);
    chk(secondary_level, 8'hff);
    // Master gate off with every sink bit set.
    i_lmu_host.wr(LMU_ADDR_KEY_LED_CONFIG, 8'hae);
    settle();
    chk({key_sink_en, keypad_internal_dimming_en, keypad_drive_style,
         3'b000}, 8'h08);
    i_lmu_host.wr(LMU_ADDR_KEY_LED_CONFIG, 8'h4a);
    settle();
    chk({key_sink_en, keypad_internal_dimming_en, keypad_drive_style,
         3'b000}, 8'ha0);
    i_lmu_host.wr(LMU_ADDR_POWER_ENABLES, 8'h00);
    settle();
    chk({key_sink_en, primary_on, secondary_on, step_up_en,
         step_up_dummy_load_en, 1'b0}, 8'h00);
    i_lmu_host.wr(LMU_ADDR_POWER_ENABLES, 8'h40);
    settle();
    chk({step_up_en, key_sink_en, primary_on, 3'b000}, 8'h58);
    i_lmu_host.wr(LMU_ADDR_GPIO_CONFIG, 8'h00);
    settle();
    chk({key_sink_ext_dimming_en, primary_ext_dimming_en,
         secondary_ext_dimming_en, gpio_oe}, 8'h00);
    rchk(LMU_ADDR_GPIO_VALUE, 8'h05);
    i_lmu_host.wr(LMU_ADDR_PRIMARY_CURRENT, 8'h12);
    i_lmu_host.wr(LMU_ADDR_SECONDARY_CURRENT, 8'h34);
    i_lmu_host.wr(LMU_ADDR_BACKLIGHT_CONFIG, 8'h03);
    settle();
    chk(primary_level, 8'h12);
    chk(secondary_level, 8'h34);
    // Fast then slow fade over the same three steps on the primary string.
    i_lmu_host.wr(LMU_ADDR_PRIMARY_CURRENT, 8'h00);
    i_lmu_host.wr(LMU_ADDR_BACKLIGHT_CONFIG, 8'h0a);
    settle();
    fade_wait(nf);
    chk(secondary_level, 8'h00);
    i_lmu_host.wr(LMU_ADDR_PRIMARY_CURRENT, 8'h03);
    settle();
    fade_wait(nf);
    chk(primary_level, 8'h03);
    i_lmu_host.wr(LMU_ADDR_BACKLIGHT_CONFIG, 8'h2a);
    i_lmu_host.wr(LMU_ADDR_PRIMARY_CURRENT, 8'h00);
    settle();
    fade_wait(ns);
    chk(primary_level, 8'h00);
    chk(8'(ns > nf), 8'h01);
    // One-cycle pulse on the reset pin.
    @(posedge clk);
    external_reset_low <= 1'b0;
    @(posedge clk);
    external_reset_low <= 1'b1;
    settle();
    rchk(LMU_ADDR_KEY_LED_CONFIG, 8'h20);
    chk(step_up_voltage_code, 8'h08);
    summarize();
  end
endmodule // tb
`default_nettype wire
